// ===== rtl/sspr_top.v
// One clock-synchronous serial channel with Avalon-MM register access.
// Assumes the peer drives the transfer clock; every pin input is synchronised.
//
// Notes on behaviour
// - A finished frame moved into the receive buffer sets the receive-full flag.
// - Receive interrupt request clears on acknowledge or on a software write.
// - Mode field 000b disables the channel, 001b selects synchronous operation.
// - Clock-edge select in the first control register picks the clock polarity.
// - Edge select one: drive on rising edges, sample on falling edges.
// - Bit 0 goes first and bits keep their true level.
// - Edge select zero: drive on falling edges, sample on rising edges.
`include "sspr_regs.vh"

module sspr_top
(
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Avalon-MM slave
    input wire [`SSPR_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Interrupt
    input wire int_ack,
    output wire irq,
    // Serial pins
    input wire transfer_clock_pin,
    input wire rx_data_pin,
    output wire tx_data_pin
);

    reg ack_q;
    reg [31:0] rdata_q;
    reg [`SSPR_MODE_MSB:0] mode_q;
    reg clock_edge_select_q;
    reg te_q;
    reg re_q;
    reg [7:0] txb_q;
    reg tx_empty_q;
    reg [7:0] rxb_q;
    reg rx_full_q;
    reg ovr_q;
    reg [`SSPR_INT_W-1:0] int_q;
    reg [`SSPR_INT_W-1:0] mask_q;

    wire clk_rise;
    wire clk_fall;
    wire rx_sync;
    wire sh_busy;
    wire sh_done;
    wire [7:0] sh_word;
    wire sync_mode;
    wire drive_en;
    wire sample_en;
    wire load;
    wire wr_acc;
    wire rd_acc;
    wire lane0;
    wire rx_store;
    wire rx_read;
    wire [`SSPR_INT_W-1:0] int_set;
    wire [`SSPR_INT_W-1:0] int_clr;
    wire hit_rxbuf;
    wire hit_rxint;

    // Address match for one register word
    function reg_hit;
        input [`SSPR_ADDR_W-1:0] addr;
        input [`SSPR_ADDR_W-1:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    // Picks the link-clock edge that belongs to the selected polarity
    function pick_edge;
        input pol;
        input edge_if_one;
        input edge_if_zero;
        begin
            pick_edge = pol ? edge_if_one : edge_if_zero;
        end
    endfunction

    // Read view of the second control register; empty and full are status only
    function [31:0] ctrl1_word;
        input te;
        input tx_empty;
        input re;
        input rx_full;
        begin
            ctrl1_word = `SSPR_WORD_ZERO;
            ctrl1_word[`SSPR_C1_TE] = te;
            ctrl1_word[`SSPR_C1_TXEMPTY] = tx_empty;
            ctrl1_word[`SSPR_C1_RE] = re;
            ctrl1_word[`SSPR_C1_RXFULL] = rx_full;
        end
    endfunction

    // Read view of the receive buffer with its overrun flag
    function [31:0] rxbuf_word;
        input [7:0] data;
        input ovr;
        begin
            rxbuf_word = `SSPR_WORD_ZERO;
            rxbuf_word[7:0] = data;
            rxbuf_word[`SSPR_RB_OVR] = ovr;
        end
    endfunction

    // Sticky event bits: a set in the same cycle as a clear wins
    function [`SSPR_INT_W-1:0] sticky_next;
        input [`SSPR_INT_W-1:0] cur;
        input [`SSPR_INT_W-1:0] set;
        input [`SSPR_INT_W-1:0] clr;
        begin
            sticky_next = (cur & ~clr) | set;
        end
    endfunction

    sspr_sync u_clk_sync
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_async(transfer_clock_pin),
        .level(),
        .rise(clk_rise),
        .fall(clk_fall)
    );

    sspr_sync u_rxd_sync
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_async(rx_data_pin),
        .level(rx_sync),
        .rise(),
        .fall()
    );

    // Bus: every access waits exactly one cycle, then completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_acc = ack_q & avs_write;
    assign rd_acc = ack_q & avs_read;
    assign lane0 = avs_byteenable[0];
    assign avs_readdata = rdata_q;

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read | avs_write) & ~ack_q;
    end

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            rdata_q <= `SSPR_WORD_ZERO;
        else
        begin
            rdata_q <= `SSPR_WORD_ZERO;
            if (avs_read && !ack_q)
            begin
                case (avs_address)
                    `SSPR_OFS_MODE: rdata_q[`SSPR_MODE_MSB:0] <= mode_q;
                    `SSPR_OFS_CTRL0: rdata_q[`SSPR_C0_CLOCK_EDGE_SELECT] <= clock_edge_select_q;
                    `SSPR_OFS_CTRL1: rdata_q <= ctrl1_word(te_q, tx_empty_q, re_q, rx_full_q);
                    `SSPR_OFS_TXBUF: rdata_q[7:0] <= txb_q;
                    `SSPR_OFS_RXBUF: rdata_q <= rxbuf_word(rxb_q, ovr_q);
                    `SSPR_OFS_RXINT: rdata_q[`SSPR_INT_W-1:0] <= int_q;
                    `SSPR_OFS_MASK: rdata_q[`SSPR_INT_W-1:0] <= mask_q;
                    // Unmapped offsets read as zero and complete normally
                    default: rdata_q <= `SSPR_WORD_ZERO;
                endcase
            end
        end
    end

    // Channel engine
    assign sync_mode = (mode_q == `SSPR_MODE_SYNC);
    assign drive_en = pick_edge(clock_edge_select_q, clk_rise, clk_fall);
    assign sample_en = pick_edge(clock_edge_select_q, clk_fall, clk_rise);
    // A byte is loaded only into an idle engine, so a write never cuts a running frame
    assign load = sync_mode & te_q & ~tx_empty_q & ~sh_busy;

    sspr_shifter u_shifter
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(~sync_mode),
        .load(load),
        .load_data(txb_q),
        .drive_en(drive_en),
        .sample_en(sample_en),
        .rx_bit(rx_sync),
        .busy(sh_busy),
        .done(sh_done),
        .rx_word(sh_word),
        .tx_bit(tx_data_pin)
    );

    // Reading the receive buffer and clearing events both key on these matches
    assign hit_rxbuf = reg_hit(avs_address, `SSPR_OFS_RXBUF);
    assign hit_rxint = reg_hit(avs_address, `SSPR_OFS_RXINT);
    assign rx_store = sh_done & re_q;
    assign rx_read = rd_acc & hit_rxbuf;

    // Mode, control and transmit buffer
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            mode_q <= `SSPR_MODE_RST;
            clock_edge_select_q <= 1'b0;
            te_q <= 1'b0;
            re_q <= 1'b0;
            txb_q <= `SSPR_BYTE_RST;
            tx_empty_q <= 1'b1;
            mask_q <= `SSPR_INT_RST;
        end
        else
        begin
            if (load)
                tx_empty_q <= 1'b1;
            if (wr_acc && lane0)
            begin
                case (avs_address)
                    `SSPR_OFS_MODE: mode_q <= avs_writedata[`SSPR_MODE_MSB:0];
                    `SSPR_OFS_CTRL0: clock_edge_select_q <= avs_writedata[`SSPR_C0_CLOCK_EDGE_SELECT];
                    `SSPR_OFS_CTRL1:
                    begin
                        te_q <= avs_writedata[`SSPR_C1_TE];
                        re_q <= avs_writedata[`SSPR_C1_RE];
                    end
                    `SSPR_OFS_TXBUF:
                    begin
                        txb_q <= avs_writedata[7:0];
                        tx_empty_q <= 1'b0;
                    end
                    `SSPR_OFS_MASK: mask_q <= avs_writedata[`SSPR_INT_W-1:0];
                    default: mode_q <= mode_q;
                endcase
            end
            // Disabled mode empties the transmit path, which is the buffer reset
            if (!sync_mode)
                tx_empty_q <= 1'b1;
        end
    end

    // Receive buffer, full flag and overrun
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rxb_q <= `SSPR_BYTE_RST;
            rx_full_q <= 1'b0;
            ovr_q <= 1'b0;
        end
        else if (!sync_mode)
        begin
            // Data stays readable; only the flags are dropped
            rx_full_q <= 1'b0;
            ovr_q <= 1'b0;
        end
        else if (rx_store)
        begin
            // A new frame beats a read landing in the same cycle
            rxb_q <= sh_word;
            rx_full_q <= 1'b1;
            if (rx_full_q && !rx_read)
                ovr_q <= 1'b1;
        end
        else if (rx_read)
            rx_full_q <= 1'b0;
    end

    // Sticky interrupt events: set wins over any clear in the same cycle
    assign int_set = {rx_store & rx_full_q & ~rx_read, rx_store};
    assign int_clr = (wr_acc && lane0 && hit_rxint) ?
                     avs_writedata[`SSPR_INT_W-1:0] : `SSPR_INT_RST;

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            int_q <= `SSPR_INT_RST;
        else
        begin
            int_q <= sticky_next(int_q, int_set, int_clr);
            if (int_ack && !int_set[`SSPR_INT_RX])
                int_q[`SSPR_INT_RX] <= 1'b0;
        end
    end

    assign irq = |(int_q & mask_q);

endmodule // sspr_top

// ===== include/sspr_regs.vh
// Register map, field positions and constants of the synchronous serial channel.
// Assumes a 32-bit Avalon-MM slave port with byte addresses, one register per word.
`ifndef SSPR_REGS_VH
`define SSPR_REGS_VH

// Register byte offsets
`define SSPR_ADDR_W 5
`define SSPR_OFS_MODE 5'h00
`define SSPR_OFS_CTRL0 5'h04
`define SSPR_OFS_CTRL1 5'h08
`define SSPR_OFS_TXBUF 5'h0C
`define SSPR_OFS_RXBUF 5'h10
`define SSPR_OFS_RXINT 5'h14
`define SSPR_OFS_MASK 5'h18

// channel_mode_reg
`define SSPR_MODE_MSB 2
`define SSPR_MODE_OFF 3'h0
`define SSPR_MODE_SYNC 3'h1
`define SSPR_MODE_RST 3'h0

// channel_ctrl_first_reg
`define SSPR_C0_CLOCK_EDGE_SELECT 0

// channel_ctrl_second_reg
`define SSPR_C1_TE 0
`define SSPR_C1_TXEMPTY 1
`define SSPR_C1_RE 2
`define SSPR_C1_RXFULL 3

// rx_buffer_reg
`define SSPR_RB_OVR 8

// rx_int_ctrl_reg: sticky events, write one to clear; mask: same bits, plain read/write
`define SSPR_INT_W 2
`define SSPR_INT_RX 0
`define SSPR_INT_OVR 1
`define SSPR_INT_RST 2'h0

// Frame
`define SSPR_FRAME_BITS 8
`define SSPR_CNT_W 4
`define SSPR_LAST_BIT 4'h7
`define SSPR_CNT_ZERO 4'h0
`define SSPR_CNT_ONE 4'h1
`define SSPR_BYTE_RST 8'h00
`define SSPR_WORD_ZERO 32'h00000000

`endif

// ===== rtl/sspr_sync.v
// Two-flop synchroniser with edge detection for one pin input.
// Assumes the pin is asynchronous to sys_clk; edges are seen in the same cycle as the synchronised level.
module sspr_sync
(
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Pin side
    input wire pin_async,
    // Synchronised side
    output wire level,
    output wire rise,
    output wire fall
);

    reg meta_q;
    reg sync_q;
    reg prev_q;

    // meta_q feeds only sync_q; edges are taken between sync_q and prev_q
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end
        else
        begin
            meta_q <= pin_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule // sspr_sync

// ===== rtl/sspr_shifter.v
// Eight-bit shift engine for one clock-synchronous frame, LSB first, no inversion.
// Assumes drive and sample strobes are one-cycle pulses that never coincide.
`include "sspr_regs.vh"

module sspr_shifter
(
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Control
    input wire clear,
    input wire load,
    input wire [7:0] load_data,
    input wire drive_en,
    input wire sample_en,
    input wire rx_bit,
    // Status and data
    output wire busy,
    output wire done,
    output wire [7:0] rx_word,
    output wire tx_bit
);

    reg [7:0] tx_sh_q;
    reg [7:0] rx_sh_q;
    reg [`SSPR_CNT_W-1:0] cnt_q;
    reg busy_q;
    reg done_q;
    reg txd_q;

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_sh_q <= `SSPR_BYTE_RST;
            rx_sh_q <= `SSPR_BYTE_RST;
            cnt_q <= `SSPR_CNT_ZERO;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            txd_q <= 1'b1;
        end
        else if (clear)
        begin
            // Disabled mode drops any partial frame
            cnt_q <= `SSPR_CNT_ZERO;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            txd_q <= 1'b1;
        end
        else
        begin
            done_q <= 1'b0;
            if (load)
            begin
                tx_sh_q <= load_data;
                cnt_q <= `SSPR_CNT_ZERO;
                busy_q <= 1'b1;
            end
            else if (busy_q && drive_en)
            begin
                txd_q <= tx_sh_q[0];
                tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            end
            else if (busy_q && sample_en)
            begin
                rx_sh_q <= {rx_bit, rx_sh_q[7:1]};
                cnt_q <= cnt_q + `SSPR_CNT_ONE;
                if (cnt_q == `SSPR_LAST_BIT)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign rx_word = rx_sh_q;
    assign tx_bit = txd_q;

endmodule // sspr_shifter

// ===== tb/sspr_top_asserts.sv
// Port-level checks for one synchronous serial channel.
// Assumes binding to sspr_top; mirrors mode, edge select and mask from bus writes.
`include "sspr_regs.vh"

module sspr_checker
(
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Register bus
    input wire [`SSPR_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Interrupt and pins
    input wire int_ack,
    input wire irq,
    input wire transfer_clock_pin,
    input wire tx_data_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_ok;
    logic [2:0] mode_q;
    logic clock_edge_select_q;
    logic [1:0] mask_q;
    logic pin_q;
    logic [7:0] drv_q;
    logic [7:0] smp_q;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            mode_q <= `SSPR_MODE_RST;
            clock_edge_select_q <= 1'b0;
            mask_q <= 2'h0;
            pin_q <= 1'b1;
            drv_q <= 8'h00;
            smp_q <= 8'h00;
        end
        else
        begin
            if (wr_ok && avs_address == `SSPR_OFS_MODE)
                mode_q <= avs_writedata[2:0];
            if (wr_ok && avs_address == `SSPR_OFS_CTRL0)
                clock_edge_select_q <= avs_writedata[0];
            if (wr_ok && avs_address == `SSPR_OFS_MASK)
                mask_q <= avs_writedata[1:0];
            pin_q <= transfer_clock_pin;
            drv_q <= {drv_q[6:0], transfer_clock_pin != pin_q && transfer_clock_pin == clock_edge_select_q};
            smp_q <= {smp_q[6:0], transfer_clock_pin != pin_q && transfer_clock_pin != clock_edge_select_q};
        end
    end
    wait_first_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("request not stalled exactly one cycle");
    read_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
        !(avs_read && !avs_waitrequest) |-> avs_readdata == 32'h00000000)
        else $error("read data not zero outside answer");
    mask_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
        mask_q == 2'h0 |-> !irq)
        else $error("interrupt with all events masked");
    mode_off_a: assert property (@(posedge sys_clk) disable iff (reset)
        avs_read && !avs_waitrequest && avs_address == `SSPR_OFS_CTRL1
        && mode_q == `SSPR_MODE_OFF |-> avs_readdata[3:1] == 3'h1)
        else $error("disabled channel shows buffer state");
    tx_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
        mode_q == `SSPR_MODE_SYNC && $past(mode_q) == `SSPR_MODE_SYNC
        && $changed(tx_data_pin) |-> drv_q[5:1] != 5'h00)
        else $error("transmit pin moved without a drive edge");
    rx_done_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(irq) && $stable(mask_q) |-> smp_q[7:2] != 6'h00)
        else $error("receive event without a recent sample edge");
    ack_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
        int_ack && mask_q == 2'h1 && smp_q == 8'h00 |=> !irq)
        else $error("acknowledge left the request set");
    w1c_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
        wr_ok && avs_address == `SSPR_OFS_RXINT && avs_writedata[0]
        && mask_q == 2'h1 && smp_q == 8'h00 |=> !irq)
        else $error("write of one left the request set");
endmodule // sspr_checker

bind sspr_top sspr_checker sspr_checker_i (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .int_ack(int_ack),
    .irq(irq), .transfer_clock_pin(transfer_clock_pin), .tx_data_pin(tx_data_pin));

// ===== tb/sspr_peer.sv
// External peer that owns the transfer clock; 320 ns link period.
// Assumes the bench calls xfer while the bus is quiet; clock stands still between frames.
module sspr_peer
(
    // Link pins
    output logic transfer_clock_pin,
    output logic rx_data_pin,
    input wire tx_data_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        transfer_clock_pin = 1'b1;
        rx_data_pin = 1'b0;
    end
    // Parks the clock at the level before a drive edge, ahead of the load
    task automatic park(input logic pol);
        transfer_clock_pin = ~pol;
        #160;
    endtask
    // Reads late in the bit cell: the device's synchroniser lag nears half a period
    task automatic xfer(input logic pol, input logic [7:0] d, input int n,
        output logic [7:0] got);
        got = 8'h00;
        transfer_clock_pin = ~pol;
        #160;
        for (int i = 0; i < n; i++)
        begin
            transfer_clock_pin = pol;
            rx_data_pin = d[i];
            #160;
            transfer_clock_pin = ~pol;
            #150;
            got[i] = tx_data_pin;
            #10;
        end
        // Released line has no pull, so it must not keep the last bit
        rx_data_pin = ~rx_data_pin;
    endtask
endmodule // sspr_peer

// ===== tb/tb_sync_serial_polarity_recovery.sv
// Self-checking bench for one synchronous serial channel.
// Assumes sspr_top with its checker bound; the peer model owns the link clock.
`include "sspr_regs.vh"

module tb_sync_serial_polarity_recovery;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [`SSPR_ADDR_W-1:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic int_ack = 1'b0;
    logic irq, transfer_clock_pin, rx_data_pin, tx_data_pin;
    logic [31:0] seed = 32'h0000B111;
    logic [31:0] q;
    logic [7:0] got, t, r;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #20 sys_clk = ~sys_clk;
    sspr_top sspr_top_i (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .int_ack(int_ack), .irq(irq),
        .transfer_clock_pin(transfer_clock_pin), .rx_data_pin(rx_data_pin),
        .tx_data_pin(tx_data_pin));
    sspr_peer sspr_peer_i (.transfer_clock_pin(transfer_clock_pin),
        .rx_data_pin(rx_data_pin), .tx_data_pin(tx_data_pin));
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        samples_checked++;
        if (act !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic give_verdict();
        $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, d};
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0)
            fail_count++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        check(q & m, e);
    endtask
    task automatic frame(input logic pol, input logic [7:0] tx, input logic [7:0] rx,
        input int n);
        // A byte written while disabled is dropped, and a park edge must not hit a loaded engine
        bus(1'b1, `SSPR_OFS_CTRL0, {7'h00, pol});
        bus(1'b1, `SSPR_OFS_MODE, 8'h01);
        sspr_peer_i.park(pol);
        bus(1'b1, `SSPR_OFS_TXBUF, tx);
        sspr_peer_i.xfer(pol, rx, n, got);
        repeat (12) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        rd_chk(`SSPR_OFS_CTRL1, 32'h0000000F, 32'h00000002);
        rd_chk(5'h1C, 32'hFFFFFFFF, 32'h00000000);
        bus(1'b1, `SSPR_OFS_MASK, 8'h01);
        bus(1'b1, `SSPR_OFS_CTRL1, 8'h05);
        for (int k = 0; k < 6; k++)
        begin
            t = (k == 0) ? 8'h01 : xs();
            r = (k == 1) ? 8'h80 : xs();
            frame(k[0], t, r, 8);
            check({24'h000000, got}, {24'h000000, t});
            check({31'h00000000, irq}, 32'h00000001);
            rd_chk(`SSPR_OFS_CTRL1, 32'h00000008, 32'h00000008);
            rd_chk(`SSPR_OFS_RXBUF, 32'h000000FF, {24'h000000, r});
            int_ack <= k[1];
            bus(1'b1, `SSPR_OFS_RXINT, {7'h00, ~k[1]});
            int_ack <= 1'b0;
            @(posedge sys_clk);
            check({31'h00000000, irq}, 32'h00000000);
        end
        // Two frames with no read between: the second overruns the first
        frame(1'b1, xs(), 8'hA5, 8);
        frame(1'b1, xs(), 8'h3C, 8);
        rd_chk(`SSPR_OFS_RXINT, 32'h00000003, 32'h00000003);
        rd_chk(`SSPR_OFS_RXBUF, 32'h000001FF, 32'h0000013C);
        bus(1'b1, `SSPR_OFS_RXINT, 8'h03);
        // Seven clocks only: an error case that must leave nothing received
        frame(1'b0, 8'h3C, 8'hC3, 7);
        check({31'h00000000, irq}, 32'h00000000);
        rd_chk(`SSPR_OFS_CTRL1, 32'h00000008, 32'h00000000);
        bus(1'b1, `SSPR_OFS_CTRL1, 8'h01);
        bus(1'b1, `SSPR_OFS_MODE, 8'h00);
        rd_chk(`SSPR_OFS_CTRL1, 32'h0000000A, 32'h00000002);
        bus(1'b1, `SSPR_OFS_MODE, 8'h01);
        bus(1'b1, `SSPR_OFS_CTRL1, 8'h05);
        bus(1'b1, `SSPR_OFS_MODE, 8'h00);
        bus(1'b1, `SSPR_OFS_MODE, 8'h01);
        bus(1'b1, `SSPR_OFS_CTRL1, 8'h05);
        frame(1'b0, 8'h5A, 8'h96, 8);
        check({24'h000000, got}, 32'h0000005A);
        rd_chk(`SSPR_OFS_RXBUF, 32'h000000FF, 32'h00000096);
        give_verdict();
    end
endmodule // tb_sync_serial_polarity_recovery
